// File: logic/tpq_edge.sv
// Purpose: synchronise a pin and report its edges
// Assumes: input is asynchronous to core_clk
// Notes: first stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none
module tpq_edge
	import tpq_pkg::*;
(
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic pin,
	output logic      level,
	output logic      rise,
	output logic      fall
);
	logic meta_q;
	logic sync_q;
	logic prev_q;

	// ****************************************************************
	// Two stage synchroniser and edge history
	// ****************************************************************
	always_ff @(posedge core_clk) begin
		if (rst) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			prev_q <= 1'b0;
		end else begin
			meta_q <= pin;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	// Edges from synchronised stages only
	assign level = sync_q;
	assign rise  = sync_q & ~prev_q;
	assign fall  = ~sync_q & prev_q;
endmodule
`default_nettype wire

// File: logic/tpq_pacer.sv
// Purpose: emits a sequence of pulses spaced by the output period
// Assumes: period is at least PULSE_CYC + 1 cycles
// Notes: pulse width fixed by PULSE_CYC; abort clears at once
`timescale 1ns/100ps
`default_nettype none
module tpq_pacer
	import tpq_pkg::*;
(
	input  wire logic                core_clk,
	input  wire logic                rst,
	input  wire logic                start,
	input  wire logic                abort,
	input  wire logic [SEQ_W-1:0]    seq_len,
	input  wire logic [PERIOD_W-1:0] period,
	output logic                     pulse,
	output logic                     busy,
	output logic                     done,
	output logic                     ready
);
	logic [PERIOD_W-1:0] tick_q;
	logic [SEQ_W-1:0]    left_q;
	logic                busy_q;
	logic                done_q;

	// ****************************************************************
	// Sequence counter and period timer
	// ****************************************************************
	always_ff @(posedge core_clk) begin
		if (rst || abort) begin
			tick_q <= '0;
			left_q <= '0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (tick_q != '0)
				tick_q <= tick_q - 1'b1;
			if (start && !busy_q && tick_q == '0) begin
				busy_q <= 1'b1;
				left_q <= (seq_len == '0) ? SEQ_W'(1) : seq_len;
				tick_q <= period;
			end else if (busy_q && tick_q == PERIOD_W'(1)) begin
				// Sequence ends one period after its last pulse began
				if (left_q == SEQ_W'(1)) begin
					busy_q <= 1'b0;
					done_q <= 1'b1;
				end else begin
					left_q <= left_q - 1'b1;
					tick_q <= period;
				end
			end
		end
	end

	// Pulse high for first PULSE_CYC cycles of each period
	assign pulse = busy_q && (tick_q > period - PERIOD_W'(PULSE_CYC));
	assign busy  = busy_q;
	assign done  = done_q;
	assign ready = !busy_q && tick_q == '0;
endmodule
`default_nettype wire

// File: logic/tpq_pkg.sv
// Purpose: shared constants and types for the trigger pulse queue
// Assumes: single clock core_clk at 200 MHz
// Notes: times are given in their own unit and converted to cycles here
package tpq_pkg;

	// ****************************************************************
	// Clock and sizes
	// ****************************************************************
	localparam int unsigned CLK_HZ         = 200000000;
	localparam int unsigned QUEUE_CAP      = 2040;
	localparam int unsigned OCC_W          = 11;
	localparam int unsigned SEQ_W          = 16;
	localparam int unsigned CNT_W          = 11;
	localparam int unsigned PERIOD_W       = 32;
	localparam int unsigned PULSE_NS       = 1000;
	localparam int unsigned PULSE_CYC      = (PULSE_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int unsigned DEF_RATE_HZ    = 52;
	localparam int unsigned DEF_PERIOD_CYC = CLK_HZ / DEF_RATE_HZ;
	localparam logic [SEQ_W-1:0] DEF_SEQ_LEN = 16'h0001;

	// ****************************************************************
	// Run state and output selections
	// ****************************************************************
	typedef enum logic [1:0] {
		TPQ_RUN_IDLE  = 2'h0,
		TPQ_RUN_ON    = 2'h1,
		TPQ_RUN_DRAIN = 2'h2,
		TPQ_RUN_ABORT = 2'h3
	} tpq_run_t;

	typedef enum logic [1:0] {
		TPQ_SEL_CORE  = 2'h0,
		TPQ_SEL_RISE0 = 2'h1,
		TPQ_SEL_FALL0 = 2'h2,
		TPQ_SEL_LVL1  = 2'h3
	} tpq_sel_t;

	typedef struct packed {
		tpq_run_t              trigger_run_state;
		logic                  queue_enable_select;
		logic                  ext_enable;
		logic                  ext_polarity_fall;
		logic [SEQ_W-1:0]      sequence_length;
		logic [PERIOD_W-1:0]   max_output_rate;
		tpq_sel_t              camera_line0_select;
		tpq_sel_t              camera_line1_select;
		tpq_sel_t              front_output0_select;
	} tpq_cfg_t;

	typedef struct packed {
		logic                  sw_request_pending_flag;
		logic                  rate_violation_flag;
		logic                  trigger_lost;
		logic [OCC_W-1:0]      queue_occupancy;
		logic                  busy;
	} tpq_stat_t;

endpackage

// File: logic/tpq_top.sv
// Purpose: software and external trigger front end with pulse queue
// Assumes: control and status are plain ports, one clock
// Notes: queue counts sequences; occupancy drops when a sequence ends
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Each accepted software trigger makes sequence_length pulses spaced by the period.
// - With queue, external and software triggers are stored and paced out.
// - With queue, writes accepted while busy; pending only when full.
// - With queue, writing a count enqueues that many requests; a zero count enqueues one.
// - Queue holds at most 2040 entries.
// - Occupancy is always visible on an output.
// - Occupancy drops only after the head sequence fully completes, or is cleared by abort or by turning the queue off.
// - Drain stop refuses inputs but finishes all queued pulses.
// - Abort stop cancels generation and empties queue immediately.
// - Queue works only when enabled; otherwise triggers bypass it.
// - Queued outputs are at least one period apart.
// - Empty queue and slow input give output in step with input.
// - Without queue, too fast input is dropped, flagged, lost event raised.
// - With queue, lost and violation only on overflow.
// - External input reacts only to the selected edge.
// - Level bypass passes input straight through, width kept, no checks; rise and fall bypass give one-cycle pulses.
// - Each output selector offers rise, fall and level bypass choices.
// - Without queue, software write while pending is ignored.
module tpq_top
	import tpq_pkg::*;
(
	input  wire logic             core_clk,
	input  wire logic             rst,
	input  wire tpq_cfg_t         cfg,
	input  wire logic             sw_trigger_request,
	input  wire logic [CNT_W-1:0] sw_trigger_count,
	input  wire logic             ext_trigger_pin,
	input  wire logic             front_input0_pin,
	input  wire logic             front_input1_pin,
	input  wire logic             rate_flag_clear,
	output tpq_stat_t             stat,
	output logic                  camera_line0,
	output logic                  camera_line1,
	output logic                  front_output0
);
	logic             ext_lvl;
	logic             ext_rise;
	logic             ext_fall;
	logic             in0_lvl;
	logic             in0_rise;
	logic             in0_fall;
	logic             in1_lvl;
	logic             in1_rise;
	logic             in1_fall;
	logic             ext_evt;
	logic             accepting;
	logic             qmode;
	logic [CNT_W-1:0] sw_n;
	logic [CNT_W-1:0] req_n;
	logic [OCC_W-1:0] occ_q;
	logic [OCC_W-1:0] room;
	logic [OCC_W-1:0] add_n;
	logic             overflow;
	logic             direct_drop;
	logic             start;
	logic             abort;
	logic             pulse;
	logic             pbusy;
	logic             pdone;
	logic             pready;
	logic             direct_pend_q;
	logic             viol_q;
	logic             lost_q;
	logic             o_l0_q;
	logic             o_l1_q;
	logic             o_f0_q;
	tpq_run_t         run_q;

	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	tpq_edge u_ext (
		.core_clk (core_clk),
		.rst      (rst),
		.pin      (ext_trigger_pin),
		.level    (ext_lvl),
		.rise     (ext_rise),
		.fall     (ext_fall)
	);
	tpq_edge u_in0 (
		.core_clk (core_clk),
		.rst      (rst),
		.pin      (front_input0_pin),
		.level    (in0_lvl),
		.rise     (in0_rise),
		.fall     (in0_fall)
	);
	tpq_edge u_in1 (
		.core_clk (core_clk),
		.rst      (rst),
		.pin      (front_input1_pin),
		.level    (in1_lvl),
		.rise     (in1_rise),
		.fall     (in1_fall)
	);

	// ****************************************************************
	// Run state: drain ends itself when all work is done
	// ****************************************************************
	always_ff @(posedge core_clk) begin
		if (rst)
			run_q <= TPQ_RUN_IDLE;
		else if (cfg.trigger_run_state == TPQ_RUN_DRAIN && run_q == TPQ_RUN_ON)
			run_q <= TPQ_RUN_DRAIN;
		else if (cfg.trigger_run_state != TPQ_RUN_DRAIN)
			run_q <= cfg.trigger_run_state;
		else if (run_q == TPQ_RUN_DRAIN && occ_q == '0 && !pbusy)
			run_q <= TPQ_RUN_IDLE;
	end

	// ****************************************************************
	// Request gathering
	// ****************************************************************
	assign accepting = (run_q == TPQ_RUN_ON);
	assign abort     = (run_q == TPQ_RUN_ABORT);
	assign qmode     = cfg.queue_enable_select;
	assign ext_evt   = cfg.ext_enable &&
		(cfg.ext_polarity_fall ? ext_fall : ext_rise);
	// Zero count treated as one so a plain strobe still triggers
	assign sw_n = !sw_trigger_request ? CNT_W'(0) :
		(sw_trigger_count == '0 ? CNT_W'(1) : sw_trigger_count);
	// Saturate so a full-count write plus an edge cannot wrap to zero
	assign req_n = !accepting ? CNT_W'(0) :
		((sw_n == '1) ? sw_n : (sw_n + CNT_W'(ext_evt)));
	assign room  = OCC_W'(QUEUE_CAP) - occ_q;
	assign overflow = qmode && (req_n > room);
	// Partial acceptance on overflow: store what fits, drop the rest
	assign add_n = (req_n > room) ? room : req_n;

	// Direct mode drops requests while a sequence or its period runs
	assign direct_drop = !qmode && accepting && (ext_evt || sw_trigger_request) &&
		(direct_pend_q || !pready);

	// ****************************************************************
	// Queue occupancy: counts whole sequences
	// ****************************************************************
	always_ff @(posedge core_clk) begin
		if (rst || abort || !qmode)
			occ_q <= '0;
		else
			occ_q <= occ_q + add_n - OCC_W'(pdone);
	end

	// Head of queue starts when pacer period has elapsed; an entry whose
	// done pulse is still being counted off must not start a second time
	assign start = qmode ? (occ_q > OCC_W'(pdone) && pready)
		: direct_pend_q;

	// ****************************************************************
	// Direct (unqueued) single pending request
	// ****************************************************************
	always_ff @(posedge core_clk) begin
		if (rst || abort || qmode)
			direct_pend_q <= 1'b0;
		else if (!direct_pend_q && accepting && (ext_evt || sw_trigger_request) && pready)
			direct_pend_q <= 1'b1;
		else if (direct_pend_q && pready)
			direct_pend_q <= 1'b0;
	end

	tpq_pacer u_pacer (
		.core_clk (core_clk),
		.rst      (rst),
		.start    (start),
		.abort    (abort),
		.seq_len  (cfg.sequence_length),
		.period   (cfg.max_output_rate),
		.pulse    (pulse),
		.busy     (pbusy),
		.done     (pdone),
		.ready    (pready)
	);

	// ****************************************************************
	// Flags: set wins over software clear
	// ****************************************************************
	always_ff @(posedge core_clk) begin
		if (rst)
			viol_q <= 1'b0;
		else if (overflow || direct_drop)
			viol_q <= 1'b1;
		else if (rate_flag_clear)
			viol_q <= 1'b0;
	end

	// One cycle lost event
	always_ff @(posedge core_clk) begin
		if (rst)
			lost_q <= 1'b0;
		else
			lost_q <= overflow || direct_drop;
	end

	// ****************************************************************
	// Output selectors with bypass choices
	// ****************************************************************
	function automatic logic pick(input tpq_sel_t s, input logic core,
		input logic r0, input logic f0, input logic l1);
		case (s)
			TPQ_SEL_CORE:  pick = core;
			TPQ_SEL_RISE0: pick = r0;
			TPQ_SEL_FALL0: pick = f0;
			TPQ_SEL_LVL1:  pick = l1;
			default:       pick = core;
		endcase
	endfunction

	// Registered outputs; level bypass keeps width, rise and fall bypass give one-cycle pulses
	always_ff @(posedge core_clk) begin
		if (rst) begin
			o_l0_q <= 1'b0;
			o_l1_q <= 1'b0;
			o_f0_q <= 1'b0;
		end else begin
			o_l0_q <= pick(cfg.camera_line0_select, pulse, in0_rise, in0_fall, in1_lvl);
			o_l1_q <= pick(cfg.camera_line1_select, pulse, in0_rise, in0_fall, in1_lvl);
			o_f0_q <= pick(cfg.front_output0_select, pulse, in0_rise, in0_fall, in1_lvl);
		end
	end

	assign camera_line0  = o_l0_q;
	assign camera_line1  = o_l1_q;
	assign front_output0 = o_f0_q;

	// ****************************************************************
	// Status
	// ****************************************************************
	assign stat.queue_occupancy = occ_q;
	assign stat.sw_request_pending_flag = qmode ? (occ_q == OCC_W'(QUEUE_CAP))
		: (direct_pend_q || pbusy || !pready);
	assign stat.rate_violation_flag = viol_q;
	assign stat.trigger_lost = lost_q;
	assign stat.busy = pbusy;

	// Unused edge/level taps kept for selector symmetry
	logic unused_ok;
	assign unused_ok = ext_lvl ^ in0_lvl ^ in1_rise ^ in1_fall;
endmodule
`default_nettype wire

// File: testbench/tpq_checker.sv
// Purpose: port checks for the trigger pulse queue
// Assumes: one clock, sync active-high reset
// Notes: bound to tpq_top from the bench top file
`timescale 1ns/100ps
`default_nettype none
module tpq_checker
	import tpq_pkg::*;
(
	input wire logic             core_clk,
	input wire logic             rst,
	input wire tpq_cfg_t         cfg,
	input wire logic             sw_trigger_request,
	input wire logic [CNT_W-1:0] sw_trigger_count,
	input wire logic             ext_trigger_pin,
	input wire logic             front_input0_pin,
	input wire logic             front_input1_pin,
	input wire logic             rate_flag_clear,
	input wire tpq_stat_t        stat,
	input wire logic             camera_line0,
	input wire logic             camera_line1,
	input wire logic             front_output0
);
	// ****************************************
	// Assertions
	// ****************************************
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	logic core0;
	assign core0 = (cfg.camera_line0_select == TPQ_SEL_CORE);

	// Queue bounds, pending meaning, one exit at a time
	occ_cap_a: assert property (stat.queue_occupancy <= QUEUE_CAP)
		else $error("occupancy over cap");
	pend_full_a: assert property (cfg.queue_enable_select && $stable(cfg) &&
		stat.sw_request_pending_flag |-> stat.queue_occupancy == QUEUE_CAP)
		else $error("pending below full");
	occ_step_a: assert property (stat.queue_occupancy < $past(stat.queue_occupancy) &&
		cfg.trigger_run_state != TPQ_RUN_ABORT |->
		stat.queue_occupancy == $past(stat.queue_occupancy) - 11'h001)
		else $error("occupancy fell by more than one");
	abort_clear_a: assert property (cfg.trigger_run_state == TPQ_RUN_ABORT [*3] |->
		stat.queue_occupancy == '0 && !stat.busy) else $error("abort left work");
	lost_flag_a: assert property (stat.trigger_lost |-> ##[0:1] stat.rate_violation_flag)
		else $error("lost without flag");
	queue_lost_a: assert property (stat.trigger_lost && cfg.queue_enable_select |->
		stat.queue_occupancy >= QUEUE_CAP - 1) else $error("lost while not full");

	// Pulse form and spacing on the core output
	pulse_width_a: assert property ($rose(camera_line0) && core0 |-> camera_line0 [*8])
		else $error("pulse too short");
	pulse_gap_a: assert property ($fell(camera_line0) && core0 |-> !camera_line0 [*8])
		else $error("pulses too close");

	// Bypass routes follow their pins
	level_pass_a: assert property (cfg.front_output0_select == TPQ_SEL_LVL1 &&
		$rose(front_input1_pin) |-> ##[1:4] front_output0) else $error("level not passed");
	edge_pass_a: assert property (cfg.camera_line1_select == TPQ_SEL_FALL0 &&
		$fell(front_input0_pin) |-> ##[1:6] camera_line1) else $error("fall not passed");

	// Main scenarios reached
	cover property (stat.queue_occupancy == QUEUE_CAP);
	cover property (stat.trigger_lost);
	cover property ($fell(stat.busy) && cfg.queue_enable_select);
endmodule
`default_nettype wire

// File: testbench/tpq_far.sv
// Purpose: camera and external source side of the trigger queue
// Assumes: pin changes on the rising edge of core_clk
// Notes: source pulse width is fixed at 37 cycles
`timescale 1ns/100ps
`default_nettype none
module tpq_far
	import tpq_pkg::*;
(
	input  wire logic core_clk,
	input  wire logic clr,
	input  wire logic fire,
	input  wire logic camera_line0,
	output logic      ext_trigger_pin,
	output int        pulses,
	output int        min_gap
);
	logic prev;
	int   since;
	int   left;

	// ****************************************
	// Source pulse and camera edge counting
	// ****************************************
	// Long pulse: the core must use one edge only
	always_ff @(posedge core_clk) begin
		if (fire && left == 0) left <= 37;
		else if (left > 0) left <= left - 1;
	end
	assign ext_trigger_pin = (left > 0);

	// Camera counts rises and keeps the shortest spacing
	always_ff @(posedge core_clk) begin
		prev  <= camera_line0;
		since <= since + 1;
		if (clr) begin
			pulses  <= 0;
			min_gap <= 32'h7FFFFFFF;
		end else if (camera_line0 && !prev) begin
			pulses <= pulses + 1;
			since  <= 1;
			if (pulses > 0 && since < min_gap) min_gap <= since;
		end
	end
endmodule
`default_nettype wire

// File: testbench/tpq_top_tb_top.sv
// Purpose: self-checking bench for the trigger pulse queue
// Assumes: period cut to 300 cycles, pulse 200 cycles
// Notes: integer model of occupancy and pulses
`timescale 1ns/100ps
`default_nettype none
module tpq_top_tb_top
	import tpq_pkg::*;
;
	logic             core_clk, rst, sw_trigger_request, rate_flag_clear, clr, fire;
	logic             ext_trigger_pin, front_input0_pin, front_input1_pin;
	logic             camera_line0, camera_line1, front_output0;
	logic [CNT_W-1:0] sw_trigger_count;
	tpq_cfg_t         cfg;
	tpq_stat_t        stat;
	int               errors, comparisons, pulses, min_gap, occ, exp_p;
	int               seed, i, n, k, m, w, len;

	// ****************************************
	// Clock, design, far side
	// ****************************************
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	tpq_top tpq_top_i (.core_clk(core_clk), .rst(rst), .cfg(cfg),
		.sw_trigger_request(sw_trigger_request), .sw_trigger_count(sw_trigger_count),
		.ext_trigger_pin(ext_trigger_pin), .front_input0_pin(front_input0_pin),
		.front_input1_pin(front_input1_pin), .rate_flag_clear(rate_flag_clear), .stat(stat),
		.camera_line0(camera_line0), .camera_line1(camera_line1), .front_output0(front_output0));
	tpq_far tpq_far_i (.core_clk(core_clk), .clr(clr), .fire(fire), .camera_line0(camera_line0),
		.ext_trigger_pin(ext_trigger_pin), .pulses(pulses), .min_gap(min_gap));

	// ****************************************
	// Tasks
	// ****************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic results;
		if (errors == 0 && comparisons > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic tick(input int c);
		repeat (c) @(negedge core_clk);
	endtask
	// One write; the model keeps only what fits
	task automatic sw(input int c);
		int acc;
		acc = (c < int'(QUEUE_CAP) - occ) ? c : int'(QUEUE_CAP) - occ;
		sw_trigger_request = 1'b1;
		sw_trigger_count   = c[CNT_W-1:0];
		tick(1);
		sw_trigger_request = 1'b0;
		tick(1);
		if (cfg.queue_enable_select && cfg.trigger_run_state == TPQ_RUN_ON) begin
			occ   += acc;
			exp_p += acc * cfg.sequence_length;
		end
	endtask
	task automatic zero;
		clr = 1'b1;
		tick(1);
		clr   = 1'b0;
		exp_p = 0;
	endtask
	task automatic restart;
		cfg.trigger_run_state = TPQ_RUN_IDLE;
		tick(2);
		cfg.trigger_run_state = TPQ_RUN_ON;
		tick(3);
	endtask
	// Bounded wait for a quiet core, then 400 spare cycles
	task automatic settle;
		w = 0;
		while ((stat.busy !== 1'b0 || stat.queue_occupancy !== '0 ||
			stat.sw_request_pending_flag !== 1'b0) && w < 20000) begin
			tick(1);
			w++;
		end
		if (w == 20000) errors++;
		occ = 0;
		tick(400);
	endtask

	// Watchdog: the run needs under 10000 cycles
	initial begin
		#(5 * 60000);
		errors++;
		results();
	end

	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		seed = 32'h2405;
		rst  = 1'b1;
		{sw_trigger_request, rate_flag_clear, clr, fire} = 4'h0;
		{front_input0_pin, front_input1_pin} = 2'h0;
		sw_trigger_count         = '0;
		cfg                      = '0;
		cfg.max_output_rate      = 32'h0000012C;
		cfg.sequence_length      = 16'h0003;
		cfg.camera_line1_select  = TPQ_SEL_FALL0;
		cfg.front_output0_select = TPQ_SEL_LVL1;
		tick(12);
		rst = 1'b0;
		tick(1);
		check({stat, camera_line0, camera_line1, front_output0}, '0, "reset");
		restart();
		// Direct: second write while pending is dropped
		zero();
		sw(1);
		check(stat.sw_request_pending_flag, 1'b1, "pending");
		sw(1);
		tick(2);
		check(stat.rate_violation_flag, 1'b1, "violation");
		settle(); // software waits for pending low
		check(pulses, 3, "direct pulses");
		check(min_gap >= 300, 1'b1, "direct gap");
		rate_flag_clear = 1'b1;
		tick(1);
		rate_flag_clear = 1'b0;
		tick(1);
		check(stat.rate_violation_flag, 1'b0, "flag clear");
		// Queue: random count, then a write while busy
		cfg.queue_enable_select = 1'b1;
		cfg.sequence_length     = 16'h0002;
		tick(3);
		zero();
		n = 2 + {$random(seed)} % 4;
		sw(n);
		sw(1);
		check(stat.queue_occupancy, occ, "count");
		check(stat.sw_request_pending_flag, 1'b0, "busy write");
		tick(300);
		check(stat.queue_occupancy, occ, "head held");
		settle();
		check(pulses, exp_p, "queue pulses");
		check(min_gap >= 300, 1'b1, "queue gap");
		// Overflow with long sequences, then abort
		cfg.sequence_length = 16'h03E8;
		sw(2047);
		sw(5);
		check(stat.queue_occupancy, occ, "full");
		check(stat.sw_request_pending_flag, 1'b1, "pending full");
		check(stat.rate_violation_flag, 1'b1, "overflow");
		cfg.trigger_run_state = TPQ_RUN_ABORT;
		tick(3);
		check(stat.queue_occupancy, 0, "abort");
		n = pulses;
		tick(600);
		check(pulses, n, "abort silent");
		occ = 0;
		restart();
		// Drain: queued work ends, new writes refused
		cfg.sequence_length = 16'h0002;
		zero();
		sw(3);
		cfg.trigger_run_state = TPQ_RUN_DRAIN;
		tick(3);
		sw(1);
		check(stat.queue_occupancy, occ, "drain refuse");
		settle();
		check(pulses, exp_p, "drain out");
		restart();
		// External edges of both polarities, empty queue
		cfg.ext_enable      = 1'b1;
		cfg.sequence_length = 16'h0001;
		zero();
		for (i = 0; i < 2; i++) begin
			cfg.ext_polarity_fall = i[0];
			tick(3);
			fire = 1'b1;
			tick(1);
			fire = 1'b0;
			w    = 0;
			while (camera_line0 !== 1'b1 && w < 60) begin
				tick(1);
				w++;
			end
			check(w <= 10 + 37 * i, 1'b1, "latency");
			settle();
		end
		check(pulses, 2, "ext pulses");
		// Bypass: width and edges pass straight through
		cfg.ext_enable          = 1'b0;
		cfg.camera_line0_select = TPQ_SEL_RISE0;
		len                     = 20 + {$random(seed)} % 30;
		{n, k, m}               = '0;
		for (i = 0; i < 60; i++) begin
			front_input0_pin = (i >= 5 && i < 25);
			front_input1_pin = (i < len);
			tick(1);
			if (front_output0 === 1'b1) n++;
			if (camera_line0 === 1'b1) k++;
			if (camera_line1 === 1'b1) m++;
		end
		check(n, len, "level width");
		check({k[7:0], m[7:0]}, 16'h0101, "edges");
		results();
	end
endmodule

bind tpq_top tpq_checker tpq_checker_i (.core_clk(core_clk), .rst(rst), .cfg(cfg),
	.sw_trigger_request(sw_trigger_request), .sw_trigger_count(sw_trigger_count),
	.ext_trigger_pin(ext_trigger_pin), .front_input0_pin(front_input0_pin),
	.front_input1_pin(front_input1_pin), .rate_flag_clear(rate_flag_clear), .stat(stat),
	.camera_line0(camera_line0), .camera_line1(camera_line1), .front_output0(front_output0));
`default_nettype wire
